// ### verilog/pcarf_top.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "pcarf_cfg.svh"
module pcarf_top #(
  parameter int modules = 5,
  parameter int count_width = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic counter_ext_clock_in,
  input wire logic [modules-1:0] module_capture_compare_pin_in,
  output logic [modules-1:0] module_capture_compare_pin_out,
  output logic [modules-1:0] module_capture_compare_pin_oe,
  input wire logic [modules-1:0] module_match,
  input wire logic [modules-1:0] module_compare_mode,
  output logic [count_width-1:0] counter_value,
  output logic watchdog_reset,
  output logic irq
);
  pcarf_pkg::pcarf_req_type req;
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] mode;
  logic [7:0] next_mode;
  logic [7:0] irq_mask;
  logic [7:0] next_irq_mask;
  logic [count_width-1:0] count;
  logic [count_width-1:0] next_count;
  logic [count_width-1:0] wdog_cmp;
  logic [count_width-1:0] next_wdog_cmp;
  logic [modules-1:0] pin_out;
  logic [modules-1:0] next_pin_out;
  logic wdog_rst;
  logic next_wdog_rst;
  logic [31:0] next_prdata;
  logic [5:0] rise;
  logic [modules-1:0] capture;
  logic [modules-1:0] event_hit;
  logic tick;
  logic overflow;
  logic wr;
  logic rd;
  logic known;
  logic [7:0] status;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_status;
  logic wr_mask;
  logic wr_count;
  logic wr_wdog;
  logic next_run;
  logic next_ovf;
  logic [modules-1:0] next_flags;

  assign req.addr = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;
  assign wr = psel & penable & req.write;
  // read data registered in the setup cycle so it stands through the access cycle
  assign rd = psel & ~penable & ~req.write;
  assign pready = 1'b1;
  assign known = (req.addr == `PCARF_CTRL_OFFSET) || (req.addr == `PCARF_MODE_OFFSET) ||
                 (req.addr == `PCARF_IRQ_STATUS_OFFSET) ||
                 (req.addr == `PCARF_IRQ_MASK_OFFSET) ||
                 (req.addr == `PCARF_COUNT_OFFSET) || (req.addr == `PCARF_WDOG_OFFSET);
  assign pslverr = psel & penable & ~known;

  pcarf_edge #(
    .width(6)
  ) u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level({counter_ext_clock_in, module_capture_compare_pin_in}),
    .rise(rise)
  );

  // external clock or core clock as count source
  assign tick = mode[`PCARF_MODE_EXTCLK_BIT] ? rise[5] : 1'b1;
  assign overflow = ctrl[`PCARF_RUN_BIT] & tick & (&count);
  // capture on pin when module not in compare mode
  assign capture = rise[modules-1:0] & ~module_compare_mode;
  assign event_hit = (module_match & module_compare_mode) | capture;
  assign status = {ctrl[`PCARF_OVF_BIT], 2'b00, ctrl[modules-1:0]};

  assign wr_ctrl = wr && (req.addr == `PCARF_CTRL_OFFSET);
  assign wr_mode = wr && (req.addr == `PCARF_MODE_OFFSET);
  assign wr_status = wr && (req.addr == `PCARF_IRQ_STATUS_OFFSET);
  assign wr_mask = wr && (req.addr == `PCARF_IRQ_MASK_OFFSET);
  assign wr_count = wr && (req.addr == `PCARF_COUNT_OFFSET);
  assign wr_wdog = wr && (req.addr == `PCARF_WDOG_OFFSET);

  // run bit changed by software only
  always_comb begin
    next_run = ctrl[`PCARF_RUN_BIT];
    if (wr_ctrl) begin
      next_run = req.wdata[`PCARF_RUN_BIT];
    end
  end

  // overflow flag: software write or clear, hardware set wins
  always_comb begin
    next_ovf = ctrl[`PCARF_OVF_BIT];
    if (wr_ctrl) begin
      next_ovf = req.wdata[`PCARF_OVF_BIT];
    end
    if (wr_status && req.wdata[`PCARF_OVF_BIT]) begin
      next_ovf = 1'h0;
    end
    if (overflow) begin
      next_ovf = 1'h1;
    end
  end

  genvar m;
  generate
    for (m = 0; m < modules; m++) begin : g_mod
      // flag set by match or capture, cleared only by software
      assign next_flags[m] = event_hit[m] | (wr_ctrl ? req.wdata[m] :
                                             (ctrl[m] & ~(wr_status & req.wdata[m])));
      // compare output toggles on its own match
      assign next_pin_out[m] = pin_out[m] ^ (module_match[m] & module_compare_mode[m]);
    end
  endgenerate

  always_comb begin
    next_ctrl = ctrl;
    next_ctrl[`PCARF_OVF_BIT] = next_ovf;
    next_ctrl[`PCARF_RUN_BIT] = next_run;
    // reserved bit never stored, reads as zero
    next_ctrl[`PCARF_RSVD_BIT] = 1'h0;
    next_ctrl[modules-1:0] = next_flags;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `PCARF_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_comb begin
    next_mode = mode;
    if (wr_mode) begin
      next_mode = req.wdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `PCARF_MODE_RESET;
    end else begin
      mode <= next_mode;
    end
  end

  always_comb begin
    next_irq_mask = irq_mask;
    if (wr_mask) begin
      next_irq_mask = req.wdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `PCARF_MASK_RESET;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  always_comb begin
    next_count = count;
    if (wr_count) begin
      next_count = req.wdata[count_width-1:0];
    end
    // counting only while running
    if (ctrl[`PCARF_RUN_BIT] && tick) begin
      next_count = count + 1'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  always_comb begin
    next_wdog_cmp = wdog_cmp;
    if (wr_wdog) begin
      next_wdog_cmp = req.wdata[count_width-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_cmp <= `PCARF_WDOG_RESET;
    end else begin
      wdog_cmp <= next_wdog_cmp;
    end
  end

  // count equal to wdog_cmp resets system when watchdog enabled and counter running
  always_comb begin
    next_wdog_rst = 1'h0;
    if (mode[`PCARF_MODE_WDOG_EN_BIT] && ctrl[`PCARF_RUN_BIT] && (count == wdog_cmp)) begin
      next_wdog_rst = 1'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_rst <= 1'h0;
    end else begin
      wdog_rst <= next_wdog_rst;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
    end else begin
      pin_out <= next_pin_out;
    end
  end

  always_comb begin
    next_prdata = prdata;
    if (rd) begin
      unique case (req.addr)
        `PCARF_CTRL_OFFSET: next_prdata = {24'h000000, ctrl};
        `PCARF_MODE_OFFSET: next_prdata = {24'h000000, mode};
        `PCARF_IRQ_STATUS_OFFSET: next_prdata = {24'h000000, status};
        `PCARF_IRQ_MASK_OFFSET: next_prdata = {24'h000000, irq_mask};
        `PCARF_COUNT_OFFSET: next_prdata = {{(32-count_width){1'b0}}, count};
        `PCARF_WDOG_OFFSET: next_prdata = {{(32-count_width){1'b0}}, wdog_cmp};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // overflow gated by its enable; module flags by mask
  assign irq = (ctrl[`PCARF_OVF_BIT] & mode[`PCARF_MODE_OVF_IE_BIT]) |
               (|(ctrl[modules-1:0] & irq_mask[modules-1:0]));
  assign module_capture_compare_pin_out = pin_out;
  assign module_capture_compare_pin_oe = module_compare_mode;
  assign counter_value = count;
  assign watchdog_reset = wdog_rst;
endmodule
`default_nettype wire

// ### verilog/pcarf_cfg.svh
`ifndef PCARF_CFG_SVH
`define PCARF_CFG_SVH
`define PCARF_CTRL_OFFSET 12'hd8
`define PCARF_MODE_OFFSET 12'hdc
`define PCARF_IRQ_STATUS_OFFSET 12'he0
`define PCARF_IRQ_MASK_OFFSET 12'he4
`define PCARF_COUNT_OFFSET 12'he8
`define PCARF_WDOG_OFFSET 12'hec
`define PCARF_OVF_BIT 7
`define PCARF_RUN_BIT 6
`define PCARF_RSVD_BIT 5
`define PCARF_MODE_OVF_IE_BIT 0
`define PCARF_MODE_EXTCLK_BIT 1
`define PCARF_MODE_WDOG_EN_BIT 6
`define PCARF_CTRL_RESET 8'h00
`define PCARF_MODE_RESET 8'h00
`define PCARF_MASK_RESET 8'h00
`define PCARF_WDOG_RESET 16'hffff
`endif

// ### verilog/pcarf_pkg.sv
package pcarf_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } pcarf_req_type;
  typedef enum logic [1:0] {
    pcarf_ext_idle = 2'b00,
    pcarf_ext_high = 2'b01
  } pcarf_ext_state_type;
endpackage

// ### verilog/pcarf_edge.sv
`timescale 1ns/1ns
`default_nettype none
module pcarf_edge #(
  parameter int width = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [width-1:0] level,
  output logic [width-1:0] rise
);
  logic [width-1:0] prev;
  logic [width-1:0] next_prev;
  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_bit
      assign rise[i] = level[i] & ~prev[i];
      assign next_prev[i] = level[i];
    end
  endgenerate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= '0;
    end else begin
      prev <= next_prev;
    end
  end
endmodule
`default_nettype wire

// ### test/pcarf_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pcarf_top_monitor #(
  parameter int modules = 5,
  parameter int count_width = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [modules-1:0] module_capture_compare_pin_in,
  input wire logic [modules-1:0] module_capture_compare_pin_oe,
  input wire logic [modules-1:0] module_capture_compare_pin_out,
  input wire logic [modules-1:0] module_match,
  input wire logic [modules-1:0] module_compare_mode,
  input wire logic [count_width-1:0] counter_value,
  input wire logic watchdog_reset,
  input wire logic irq
);
  logic run, ovie, wr;
  logic [modules-1:0] msk, pq;
  assign wr = psel && penable && pwrite;
  // shadow of software settings and previous capture pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
      ovie <= 1'b0;
      msk <= '0;
      pq <= '0;
    end else begin
      pq <= module_capture_compare_pin_in;
      if (wr && paddr == 12'hd8) run <= pwdata[6];
      if (wr && paddr == 12'hdc) ovie <= pwdata[0];
      if (wr && paddr == 12'he4) msk <= pwdata[modules-1:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_run_stop: assert property (!run && !(wr && paddr == 12'he8) |=> $stable(counter_value))
    else $error("counter moved while stopped");
  a_ovf_irq: assert property (ovie && run && counter_value == '1 && !wr ##1 counter_value == '0
    |-> ##[0:2] irq) else $error("no interrupt on overflow");
  a_irq_hold: assert property (irq && !wr |=> irq)
    else $error("flag cleared without software");
  a_cap_flag: assert property (|(module_capture_compare_pin_in & ~pq & ~module_compare_mode & msk)
    |-> ##[1:3] irq) else $error("capture not flagged");
  a_match_flag: assert property (|(module_match & module_compare_mode & msk) |-> ##[1:2] irq)
    else $error("match not flagged");
  a_wdog_run: assert property (watchdog_reset |-> $past(run))
    else $error("watchdog fired while stopped");
  a_pin_dir: assert property (module_capture_compare_pin_oe == module_compare_mode)
    else $error("pin direction wrong");
  a_pin_toggle: assert property (|(module_match & module_compare_mode) |=>
    module_capture_compare_pin_out != $past(module_capture_compare_pin_out))
    else $error("compare output did not toggle");
  a_reset_clear: assert property ($rose(presetn) |-> !irq && counter_value == '0)
    else $error("state not cleared by reset");
  c_wdog: cover property (watchdog_reset);
  c_irq: cover property ($rose(irq));
  c_stop: cover property ($fell(run));
endmodule
bind pcarf_top pcarf_top_monitor #(.modules(modules), .count_width(count_width)) u_mon (.*);
`default_nettype wire

// ### test/pcarf_pins.sv
`timescale 1ns/1ns
`default_nettype none
module pcarf_pins (
  input wire logic pclk,
  input wire logic ext_go,
  input wire logic [4:0] cap,
  output logic eclk,
  output logic [4:0] pin
);
  initial begin
    eclk = 1'b0;
    pin = 5'h0;
  end
  always @(posedge pclk) begin
    eclk <= ext_go ? ~eclk : 1'b0;
    pin <= cap;
  end
endmodule
`default_nettype wire

// ### test/tb_pcarf_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pcarf_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, counter_ext_clock_in;
  logic watchdog_reset, irq, ext_go, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, a;
  logic [4:0] module_capture_compare_pin_in, module_capture_compare_pin_out, cap;
  logic [4:0] module_capture_compare_pin_oe, module_match, module_compare_mode;
  logic [15:0] counter_value;
  int n_mismatch, n_checks, cyc;
  pcarf_top dut (.*);
  pcarf_pins u_pins (.pclk(pclk), .ext_go(ext_go), .cap(cap), .eclk(counter_ext_clock_in),
    .pin(module_capture_compare_pin_in));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ext_go} = '0;
    {module_match, module_compare_mode, cap, n_mismatch, n_checks, cyc} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'hd8, 32'h0); chk("ctrl", rd, 32'h0);
    apb(1'b0, 12'h100, 32'h0); chk("slverr", err, 32'h1);
    chk("unmapped", rd, 32'h0);
    apb(1'b1, 12'hdc, 32'h41); apb(1'b1, 12'he4, 32'h1f);
    apb(1'b1, 12'hec, 32'h20); apb(1'b1, 12'he8, 32'hfff0);
    // run with the reserved bit written as zero
    apb(1'b1, 12'hd8, 32'h40);
    a = 32'h0;
    while (watchdog_reset !== 1'b1 && a < 32'd200) begin
      @(posedge pclk);
      a++;
    end
    chk("wdog", watchdog_reset, 32'h1);
    apb(1'b0, 12'hd8, 32'h0); chk("ctrl", rd, 32'hc0);
    chk("irq", irq, 32'h1);
    apb(1'b1, 12'hd8, 32'h0); apb(1'b0, 12'he8, 32'h0);
    a = rd;
    apb(1'b0, 12'he8, 32'h0); chk("count", rd, a);
    apb(1'b1, 12'hdc, 32'h02); apb(1'b1, 12'he8, 32'h0); apb(1'b1, 12'hd8, 32'h40);
    repeat (10) @(posedge pclk);
    ext_go <= 1'b1;
    repeat (8) @(posedge pclk);
    ext_go <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'he8, 32'h0); chk("ext count", rd, 32'h4);
    apb(1'b1, 12'hd8, 32'h0);
    module_compare_mode <= 5'h04;
    @(posedge pclk);
    chk("oe", module_capture_compare_pin_oe, 32'h4);
    module_match <= 5'h04;
    cap <= 5'h01;
    @(posedge pclk);
    module_match <= 5'h0;
    cap <= 5'h0;
    repeat (4) @(posedge pclk);
    chk("pin out", module_capture_compare_pin_out, 32'h4);
    apb(1'b0, 12'hd8, 32'h0); chk("flags", rd, 32'h05);
    chk("irq", irq, 32'h1);
    apb(1'b1, 12'he0, 32'h05); apb(1'b0, 12'he0, 32'h0); chk("status", rd, 32'h0);
    chk("irq", irq, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
